// ===== cid_regs_pkg.sv
// constants, field positions, reset values and types of the operational register set
// assumes a 250 MHz core clock and an apb slave with byte addresses on 8 bits
package cid_regs_pkg;

  // ----------------------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------------------
  localparam logic [7:0] OFS_INDIRECT = 8'h00;
  localparam logic [7:0] OFS_COUNTER  = 8'h04;
  localparam logic [7:0] OFS_PC       = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0c;
  localparam logic [7:0] OFS_RAMSEL   = 8'h10;
  localparam logic [7:0] OFS_ROMPAGE  = 8'h14;
  localparam logic [7:0] OFS_LINE     = 8'h28;
  localparam logic [7:0] OFS_CONTROL  = 8'h40;
  localparam logic [7:0] OFS_MASK     = 8'h44;

  // ----------------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------------
  localparam int ST_POWERDOWN = 3;
  localparam int ST_TIMEOUT   = 4;
  localparam int ST_IO_PAGE   = 6;
  localparam int LN_FSK_POWER = 3;
  localparam int LN_BAT_EN    = 5;
  localparam int LN_PLL_EN    = 6;
  localparam int LN_IDLE_SEL  = 7;
  localparam int CT_GIE       = 6;
  localparam int CT_EDGE_SEL  = 7;

  // writable bits: status keeps carry, aux carry, zero and page; line keeps bits 3,5,6,7
  localparam logic [7:0] STATUS_WR_MASK = 8'h47;
  localparam logic [7:0] LINE_WR_MASK   = 8'he8;

  // ----------------------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------------------
  localparam logic [7:0] STATUS_RST  = 8'h18;
  localparam logic [7:0] LINE_RST    = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] MASK_RST    = 8'h00;
  localparam logic [7:0] RAMSEL_RST  = 8'h00;
  localparam logic [7:0] ROMPAGE_RST = 8'h00;
  localparam logic [7:0] COUNTER_RST = 8'h00;

  // ----------------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------------
  localparam int PC_W        = 14;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_PTR_W = 3;
  localparam int RAM_WORDS   = 256;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_SLEEP
  } power_state_t;

  // upper four address bits come from the rom page field
  function automatic logic [PC_W-1:0] pc_with_page(input logic [3:0] page,
                                                   input logic [9:0] low);
    pc_with_page = {page, low};
  endfunction : pc_with_page

  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction : fell

endpackage : cid_regs_pkg

// ===== return_stack.sv
// eight-level circular return stack for program counter values
// assumes push and pop never arrive in the same cycle
`timescale 1ns/1ps
module return_stack
  import cid_regs_pkg::*;
(
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  // stack control
  input  wire logic              i_push,
  input  wire logic              i_pop,
  input  wire logic [PC_W-1:0]   i_push_data,
  // top entry
  output logic      [PC_W-1:0]   o_top
);

  logic [PC_W-1:0]        stack_mem [0:STACK_DEPTH-1];
  logic [STACK_PTR_W-1:0] ptr_ff;
  logic [STACK_PTR_W-1:0] top_idx;

  // overflow wraps and silently overwrites the oldest entry, like the core does
  assign top_idx = ptr_ff - 3'h1;
  assign o_top   = stack_mem[top_idx];

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ptr_ff <= '0;
    end else if (i_push) begin
      ptr_ff <= ptr_ff + 3'h1;
    end else if (i_pop) begin
      ptr_ff <= top_idx;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_push) begin
      stack_mem[ptr_ff] <= i_push_data;
    end
  end

endmodule : return_stack

// ===== cid_mcu_operational_registers.sv
// operational registers of the caller-id core: pc, status, line status, power modes
// assumes an apb master, one core instruction strobe per cycle, inputs synchronous
//
// Contract
// - indirect port has no storage; it reaches the ram word picked by ram select
// - jump loads its target into the low ten pc bits
// - call pushes pc plus one on the eight-level stack, loads low ten bits
// - every return kind reloads the pc from the top of the stack
// - move and add accumulator to pc clear pc bits eight and nine
// - table read adds accumulator to pc, keeping bits eight and nine
// - jump, call, add and move copy the four page bits into pc bits 10 to 13
// - power-down flag set at power-on or watchdog clear, cleared by sleep
// - time-out flag set by sleep, watchdog clear or power-up, cleared by time-out
// - flag pairs after each wake, time-out and power-up follow the event table
// - status bit 6 selects page 0 or 1 of the paged control registers
// - status bit 7 shows call-waiting output, 0 means data present
// - ram select bits 0-5 pick a register, bits 6-7 pick one of four banks
// - line bits 0 and 1 show ring and carrier detect, read only, low valid
// - line bit 2 shows the live demodulated fsk data bit, read only
// - line bit 3 powers the fsk demodulator up when 1, down when 0
// - line bit 4 reads 0 on low battery; bit 5 enables low-battery detection
// - line bit 7 picks sleep or idle; wake resumes at the next instruction
// - mode follows line bits 7 and 6: sleep, idle, green or normal clocks
// - wake sources act per mode: wake, interrupt, reset or ignore
// - external pin wake is gated by mask bits 1 to 3 and global enable
// - ring-time, port 9 and pins 1-3 act on falling edges; pin 0 per edge bit
// - edge bit 0 makes pin 0 rising-edge, 1 makes it falling-edge
`timescale 1ns/1ps
module cid_mcu_operational_registers
  import cid_regs_pkg::*;
(
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // core instruction strobes
  input  wire logic              i_step,
  input  wire logic              i_jmp,
  input  wire logic              i_call,
  input  wire logic              i_ret,
  input  wire logic              i_return_interrupt_instr,
  input  wire logic              i_mov_pc,
  input  wire logic              i_add_pc,
  input  wire logic              i_tbl,
  input  wire logic [9:0]        i_target,
  input  wire logic [7:0]        i_acc,
  input  wire logic              i_watchdog_clear_instr,
  input  wire logic              i_sleep,
  input  wire logic              i_eni,
  input  wire logic              i_disi,
  output logic      [PC_W-1:0]   o_pc,
  // line status inputs and controls
  input  wire logic              i_ring_detect_n,
  input  wire logic              i_carrier_detect_n,
  input  wire logic              i_fsk_data,
  input  wire logic              i_battery_low_n,
  input  wire logic              i_cw_none,
  output logic                   o_fsk_power,
  output logic                   o_battery_detect_enable,
  output logic                   o_io_page,
  output logic      [7:0]        o_ram_bank_select,
  // wake-up sources
  input  wire logic              i_count_pulse,
  input  wire logic              i_wdt_timeout,
  input  wire logic [7:0]        i_port9,
  input  wire logic              i_ring_time_n,
  input  wire logic [3:0]        i_ext_pin,
  // power mode outputs
  output logic                   o_cpu_clk_en,
  output logic                   o_lf_clk_en,
  output logic                   o_pll_clk_en,
  output logic                   o_wake,
  output logic                   o_irq_req,
  output logic                   o_reset_req
);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  logic [7:0]      counter_ff;
  logic [7:0]      status_ff;
  logic [7:0]      ramsel_ff;
  logic [7:0]      rompage_ff;
  logic [7:0]      line_ff;
  logic [7:0]      control_ff;
  logic [7:0]      mask_ff;
  logic [PC_W-1:0] pc_ff;
  logic [31:0]     prdata_ff;
  logic [3:0]      ext_prev_ff;
  logic [7:0]      port9_prev_ff;
  logic            ring_prev_ff;
  logic            wake_ff;
  logic            irq_ff;
  logic            reset_req_ff;
  power_state_t    mode_ff;
  logic [7:0]      ram_mem [0:RAM_WORDS-1];

  // ----------------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------------
  logic bus_setup;
  logic bus_access;
  logic bus_wr;
  logic addr_hit;
  logic wr_indirect;
  logic wr_counter;
  logic wr_pc;
  logic wr_status;
  logic wr_ramsel;
  logic wr_rompage;
  logic wr_line;
  logic wr_control;
  logic wr_mask;
  logic [7:0] wdata;

  assign bus_setup  = i_psel & ~i_penable;
  assign bus_access = i_psel & i_penable;
  assign bus_wr     = bus_access & i_pwrite;
  assign wdata      = i_pwdata[7:0];
  assign addr_hit   = (i_paddr == OFS_INDIRECT) | (i_paddr == OFS_COUNTER)
                    | (i_paddr == OFS_PC)       | (i_paddr == OFS_STATUS)
                    | (i_paddr == OFS_RAMSEL)   | (i_paddr == OFS_ROMPAGE)
                    | (i_paddr == OFS_LINE)     | (i_paddr == OFS_CONTROL)
                    | (i_paddr == OFS_MASK);

  assign wr_indirect = bus_wr & (i_paddr == OFS_INDIRECT);
  assign wr_counter  = bus_wr & (i_paddr == OFS_COUNTER);
  assign wr_pc       = bus_wr & (i_paddr == OFS_PC);
  assign wr_status   = bus_wr & (i_paddr == OFS_STATUS);
  assign wr_ramsel   = bus_wr & (i_paddr == OFS_RAMSEL);
  assign wr_rompage  = bus_wr & (i_paddr == OFS_ROMPAGE);
  assign wr_line     = bus_wr & (i_paddr == OFS_LINE);
  assign wr_control  = bus_wr & (i_paddr == OFS_CONTROL);
  assign wr_mask     = bus_wr & (i_paddr == OFS_MASK);

  // zero wait states: read data is captured in the setup phase
  assign o_pready  = 1'b1;
  assign o_pslverr = bus_access & ~addr_hit;
  assign o_prdata  = prdata_ff;

  // ----------------------------------------------------------------------------
  // read values
  // ----------------------------------------------------------------------------
  logic [7:0] battery_bit;
  logic [7:0] status_rd;
  logic [7:0] line_rd;
  logic [7:0] indirect_rd;
  logic [7:0] rd_byte;

  // with detection disabled the battery reads as normal
  assign battery_bit = {7'h00, line_ff[LN_BAT_EN] ? i_battery_low_n : 1'b1};
  assign status_rd   = {i_cw_none, status_ff[6:0]};
  assign line_rd     = {line_ff[7:5], battery_bit[0], line_ff[LN_FSK_POWER],
                        i_fsk_data, i_carrier_detect_n, i_ring_detect_n};
  assign indirect_rd = ram_mem[ramsel_ff];

  assign rd_byte = (i_paddr == OFS_INDIRECT) ? indirect_rd
                 : (i_paddr == OFS_COUNTER)  ? counter_ff
                 : (i_paddr == OFS_PC)       ? pc_ff[7:0]
                 : (i_paddr == OFS_STATUS)   ? status_rd
                 : (i_paddr == OFS_RAMSEL)   ? ramsel_ff
                 : (i_paddr == OFS_ROMPAGE)  ? rompage_ff
                 : (i_paddr == OFS_LINE)     ? line_rd
                 : (i_paddr == OFS_CONTROL)  ? control_ff
                 : (i_paddr == OFS_MASK)     ? mask_ff
                 : 8'h00;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      prdata_ff <= 32'h0000_0000;
    end else if (bus_setup & ~i_pwrite) begin
      prdata_ff <= {24'h00_0000, rd_byte};
    end
  end

  // data ram is not reset; bank and register come from the select register
  always_ff @(posedge i_clock) begin
    if (wr_indirect) begin
      ram_mem[ramsel_ff] <= wdata;
    end
  end

  // ----------------------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------------------
  logic [PC_W-1:0] pc_plus1;
  logic [PC_W-1:0] stack_top;
  logic [PC_W-1:0] nxt_pc;
  logic [7:0]      low_sum;
  logic [3:0]      page;
  logic            any_ret;

  assign page     = rompage_ff[3:0];
  assign pc_plus1 = pc_ff + 14'h0001;
  assign low_sum  = pc_ff[7:0] + i_acc;
  assign any_ret  = i_ret | i_return_interrupt_instr;

  assign nxt_pc = (i_call | i_jmp) ? pc_with_page(page, i_target)
                : i_mov_pc         ? pc_with_page(page, {2'b00, i_acc})
                : wr_pc            ? pc_with_page(page, {2'b00, wdata})
                : i_add_pc         ? pc_with_page(page, {2'b00, low_sum})
                : i_tbl            ? {pc_ff[PC_W-1:8], low_sum}
                : any_ret          ? stack_top
                : i_step           ? pc_plus1
                : pc_ff;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      pc_ff <= '0;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  return_stack u_return_stack (
    .i_clock     (i_clock),
    .i_reset     (i_reset),
    .i_push      (i_call),
    .i_pop       (any_ret & ~i_call),
    .i_push_data (pc_plus1),
    .o_top       (stack_top)
  );

  assign o_pc = pc_ff;

  // ----------------------------------------------------------------------------
  // counter and edge sources
  // ----------------------------------------------------------------------------
  logic       counter_ovf;
  logic [3:0] ext_edge;
  logic [3:0] ext_event;
  logic       ext_req;
  logic       p9_ring_fall;
  logic       pin0_rise;
  logic       pin0_fall;

  // a bus write to the counter takes the cycle, the pulse is dropped
  assign counter_ovf = i_count_pulse & ~wr_counter & (counter_ff == 8'hff);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      counter_ff <= COUNTER_RST;
    end else if (wr_counter) begin
      counter_ff <= wdata;
    end else if (i_count_pulse) begin
      counter_ff <= counter_ff + 8'h01;
    end
  end

  // history tracks the pins through reset, so release never shows a false edge
  always_ff @(posedge i_clock) begin
    ext_prev_ff   <= i_ext_pin;
    port9_prev_ff <= i_port9;
    ring_prev_ff  <= i_ring_time_n;
  end

  assign pin0_rise   = ~ext_prev_ff[0] & i_ext_pin[0];
  assign pin0_fall   = fell(ext_prev_ff[0], i_ext_pin[0]);
  assign ext_edge[0] = control_ff[CT_EDGE_SEL] ? pin0_fall : pin0_rise;
  assign ext_edge[1] = fell(ext_prev_ff[1], i_ext_pin[1]);
  assign ext_edge[2] = fell(ext_prev_ff[2], i_ext_pin[2]);
  assign ext_edge[3] = fell(ext_prev_ff[3], i_ext_pin[3]);
  assign p9_ring_fall = (|(port9_prev_ff & ~i_port9))
                      | fell(ring_prev_ff, i_ring_time_n);

  // pins 2 and 3 share one flag, so they share one mask bit
  assign ext_event = ext_edge & {mask_ff[3], mask_ff[3], mask_ff[2], mask_ff[1]};
  assign ext_req   = (|ext_event) & control_ff[CT_GIE];

  // ----------------------------------------------------------------------------
  // power modes and wake-up matrix
  // ----------------------------------------------------------------------------
  logic         in_run;
  logic         in_idle;
  logic         in_sleep;
  logic         sleep_take;
  logic         wake_now;
  logic         irq_now;
  logic         reset_now;
  power_state_t nxt_mode;

  assign in_run     = (mode_ff == MODE_RUN);
  assign in_idle    = (mode_ff == MODE_IDLE);
  assign in_sleep   = (mode_ff == MODE_SLEEP);
  assign sleep_take = i_sleep & in_run;

  assign wake_now  = in_idle & (counter_ovf | i_wdt_timeout | p9_ring_fall | ext_req);
  assign irq_now   = ~in_sleep & (counter_ovf | ext_req);
  assign reset_now = (i_wdt_timeout & ~in_idle) | (p9_ring_fall & in_sleep);

  // pc is frozen while stopped, so a wake resumes after the sleep instruction
  // a reset request beats a sleep instruction in the same cycle
  assign nxt_mode = reset_now ? MODE_RUN
                  : sleep_take ? (line_ff[LN_IDLE_SEL] ? MODE_IDLE : MODE_SLEEP)
                  : wake_now ? MODE_RUN
                  : mode_ff;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      mode_ff <= MODE_RUN;
    end else begin
      unique case (mode_ff)
        MODE_RUN:   mode_ff <= nxt_mode;
        MODE_IDLE:  mode_ff <= nxt_mode;
        MODE_SLEEP: mode_ff <= nxt_mode;
        default:    mode_ff <= MODE_RUN;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wake_ff      <= 1'b0;
      irq_ff       <= 1'b0;
      reset_req_ff <= 1'b0;
    end else begin
      wake_ff      <= wake_now;
      irq_ff       <= irq_now;
      reset_req_ff <= reset_now;
    end
  end

  assign o_wake       = wake_ff;
  assign o_irq_req    = irq_ff;
  assign o_reset_req  = reset_req_ff;
  assign o_cpu_clk_en = in_run;
  assign o_lf_clk_en  = ~in_sleep;
  assign o_pll_clk_en = in_run & line_ff[LN_PLL_EN];

  // ----------------------------------------------------------------------------
  // status flags and software registers
  // ----------------------------------------------------------------------------
  logic [7:0] nxt_status;
  logic [7:0] status_base;
  logic       nxt_timeout;
  logic       nxt_powerdown;

  // set beats clear on both flags
  assign nxt_timeout   = (sleep_take | i_watchdog_clear_instr) ? 1'b1
                       : i_wdt_timeout ? 1'b0 : status_ff[ST_TIMEOUT];
  assign nxt_powerdown = i_watchdog_clear_instr ? 1'b1
                       : sleep_take ? 1'b0 : status_ff[ST_POWERDOWN];
  assign status_base   = wr_status ? (wdata & STATUS_WR_MASK) : status_ff;
  assign nxt_status    = {1'b0, status_base[ST_IO_PAGE], 1'b0,
                          nxt_timeout, nxt_powerdown, status_base[2:0]};

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      status_ff <= STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ramsel_ff  <= RAMSEL_RST;
      rompage_ff <= ROMPAGE_RST;
      mask_ff    <= MASK_RST;
    end else begin
      if (wr_ramsel) begin
        ramsel_ff <= wdata;
      end
      if (wr_rompage) begin
        rompage_ff <= wdata;
      end
      if (wr_mask) begin
        mask_ff <= wdata;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      line_ff <= LINE_RST;
    end else if (wr_line) begin
      line_ff <= wdata & LINE_WR_MASK;
    end
  end

  // enable instructions win over a bus write and over an accepted interrupt
  logic [7:0] control_base;
  logic       nxt_gie;

  assign control_base = wr_control ? wdata : control_ff;
  assign nxt_gie      = (i_eni | i_return_interrupt_instr) ? 1'b1
                      : (i_disi | irq_now) ? 1'b0 : control_base[CT_GIE];

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      control_ff <= CONTROL_RST;
    end else begin
      control_ff <= {control_base[7], nxt_gie, control_base[5:0]};
    end
  end

  assign o_fsk_power             = line_ff[LN_FSK_POWER];
  assign o_battery_detect_enable = line_ff[LN_BAT_EN];
  assign o_io_page               = status_ff[ST_IO_PAGE];
  assign o_ram_bank_select       = ramsel_ff;

endmodule : cid_mcu_operational_registers

// ===== cid_ops_props.sv
// concurrent checks on the operational register block ports
// assumes one clock domain; bound into every instance of the block
`timescale 1ns/1ps
module cid_ops_props
  import cid_regs_pkg::*;
(
  // clock and reset
  input wire logic            i_clock,
  input wire logic            i_reset,
  // core strobes
  input wire logic            i_jmp,
  input wire logic            i_mov_pc,
  input wire logic            i_sleep,
  input wire logic            i_wdt_timeout,
  input wire logic [9:0]      i_target,
  input wire logic [7:0]      i_acc,
  // watched outputs
  input wire logic [PC_W-1:0] o_pc,
  input wire logic            o_cpu_clk_en,
  input wire logic            o_lf_clk_en,
  input wire logic            o_pll_clk_en,
  input wire logic            o_wake,
  input wire logic            o_reset_req
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // --------------------------------
  // assertions
  // --------------------------------
  jmp_low_a: assert property (i_jmp |=> o_pc[9:0] == $past(i_target))
    else $error("jump target missing from low pc bits");
  mov_clear_a: assert property (i_mov_pc |=> o_pc[9:0] == {2'b00, $past(i_acc)})
    else $error("move to pc kept upper low bits");
  sleep_stop_a: assert property (
    i_sleep && o_cpu_clk_en && !i_wdt_timeout |=> !o_cpu_clk_en && !o_pll_clk_en)
    else $error("sleep left a clock running");
  pll_run_a: assert property (o_pll_clk_en |-> o_cpu_clk_en)
    else $error("fast clock outside normal mode");
  lf_run_a: assert property (o_cpu_clk_en |-> o_lf_clk_en)
    else $error("slow clock off while cpu runs");
  wake_run_a: assert property (o_wake |-> o_cpu_clk_en ##1 !o_wake)
    else $error("wake did not resume run");
  wdt_reset_a: assert property (i_wdt_timeout && o_cpu_clk_en |=> o_reset_req)
    else $error("time-out in run gave no reset");
  reset_run_a: assert property (o_reset_req |-> o_cpu_clk_en)
    else $error("reset request left cpu stopped");
  cover property (o_wake);
  cover property (o_reset_req);
  cover property (i_jmp);
endmodule : cid_ops_props

bind cid_mcu_operational_registers cid_ops_props u_props (.*);

// ===== cid_mcu_operational_registers_tb_top.sv
// bench for the operational register block: registers, pc strobes, power modes
// assumes zero-wait apb and one-cycle core strobes
`timescale 1ns/1ps
module cid_mcu_operational_registers_tb_top
  import cid_regs_pkg::*;
;
  logic        i_clock, i_reset, i_ring_detect_n, i_carrier_detect_n, i_fsk_data, err;
  logic        i_battery_low_n, i_cw_none, i_ring_time_n, i_psel, i_penable, i_pwrite;
  logic        o_pready, o_pslverr, o_fsk_power, o_battery_detect_enable, o_io_page;
  logic        o_cpu_clk_en, o_lf_clk_en, o_pll_clk_en, o_wake, o_irq_req, o_reset_req;
  logic [7:0]  i_paddr, i_acc, i_port9, o_ram_bank_select;
  logic [31:0] i_pwdata, o_prdata, rdat;
  logic [42:0] bus;
  logic [13:0] op, o_pc;
  logic [9:0]  i_target;
  logic [3:0]  i_ext_pin;
  int          fail_count = 0, n_compared = 0, cyc = 0;

  assign {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = bus;
  cid_mcu_operational_registers dut (
    .i_step(op[0]), .i_jmp(op[1]), .i_call(op[2]), .i_ret(op[3]), .i_return_interrupt_instr(op[4]),
    .i_mov_pc(op[5]), .i_add_pc(op[6]), .i_tbl(op[7]), .i_watchdog_clear_instr(op[8]), .i_sleep(op[9]),
    .i_eni(op[10]), .i_disi(op[11]), .i_wdt_timeout(op[12]), .i_count_pulse(op[13]), .*);

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  // a hang anywhere counts as a mismatch
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      complete_run();
    end
  end
  // --------------------------------
  // shared tasks
  // --------------------------------
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    bus <= {2'b10, w, a, d};
    @(posedge i_clock);
    bus[41] <= 1'b1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    rdat = o_prdata;
    err = o_pslverr;
    bus[42:41] <= 2'b00;
    #1;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read data", rdat, e);
  endtask : rd
  task pl(input int k, input logic [9:0] t, input logic [7:0] a);
    @(posedge i_clock);
    op[k] <= 1'b1;
    i_target <= t;
    i_acc <= a;
    @(posedge i_clock);
    op <= 14'h0;
    #1;
  endtask : pl
  task go(input int k, input logic [9:0] t, input logic [7:0] a, input logic [13:0] e);
    pl(k, t, a);
    chk("pc", 32'(o_pc), 32'(e));
  endtask : go
  // waits for a wake or reset pulse, then judges it with irq and cpu clock
  task see(input logic [31:0] e);
    repeat (8) begin
      if ((o_wake | o_reset_req) === 1'b1) break;
      @(posedge i_clock);
      #1;
    end
    chk("wake flags", 32'({o_wake, o_reset_req, o_irq_req, o_cpu_clk_en}), e);
  endtask : see
  task complete_run;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  // --------------------------------
  // scenarios
  // --------------------------------
  task t_line;
    rd(OFS_STATUS, 32'h98);
    @(posedge i_clock);
    i_cw_none <= 1'b0;
    rd(OFS_STATUS, 32'h18);
    @(posedge i_clock);
    i_cw_none <= 1'b1;
    apb(1'b1, OFS_LINE, 32'hff);
    rd(OFS_LINE, 32'hed);
    chk("line out", 32'({o_fsk_power, o_battery_detect_enable, o_pll_clk_en}), 32'h7);
    apb(1'b1, OFS_LINE, 32'h00);
    rd(OFS_LINE, 32'h15);
    apb(1'b1, OFS_STATUS, 32'h40);
    chk("io page", 32'(o_io_page), 32'h1);
    apb(1'b1, OFS_STATUS, 32'h00);
  endtask : t_line
  task t_ram;
    apb(1'b1, OFS_RAMSEL, 32'h45);
    apb(1'b1, OFS_INDIRECT, 32'ha5);
    apb(1'b1, OFS_RAMSEL, 32'h85);
    apb(1'b1, OFS_INDIRECT, 32'h3c);
    apb(1'b1, OFS_RAMSEL, 32'h45);
    rd(OFS_INDIRECT, 32'ha5);
    chk("ram select", 32'(o_ram_bank_select), 32'h45);
    rd(8'hfc, 32'h0);
    chk("slave error", 32'(err), 32'h1);
  endtask : t_ram
  task t_pc;
    apb(1'b1, OFS_ROMPAGE, 32'h3);
    go(1, 10'h3f0, 8'h00, 14'h0ff0);
    go(7, 10'h000, 8'h20, 14'h0f10);
    go(2, 10'h020, 8'h00, 14'h0c20);
    go(6, 10'h000, 8'h05, 14'h0c25);
    go(5, 10'h000, 8'h80, 14'h0c80);
    go(3, 10'h000, 8'h00, 14'h0f11);
    go(0, 10'h000, 8'h00, 14'h0f12);
  endtask : t_pc
  task t_idle;
    apb(1'b1, OFS_MASK, 32'h02);
    apb(1'b1, OFS_LINE, 32'h80);
    pl(10, 10'h0, 8'h0);
    rd(OFS_CONTROL, 32'h40);
    go(9, 10'h0, 8'h0, 14'h0f12);
    chk("idle clocks", 32'({o_cpu_clk_en, o_lf_clk_en, o_pll_clk_en}), 32'h2);
    rd(OFS_STATUS, 32'h90);
    @(posedge i_clock);
    i_ext_pin[0] <= 1'b1;
    see(32'hb);
    chk("pc", 32'(o_pc), 32'h0f12);
    pl(8, 10'h0, 8'h0);
    pl(12, 10'h0, 8'h0);
    see(32'h5);
    rd(OFS_STATUS, 32'h88);
    pl(8, 10'h0, 8'h0);
    rd(OFS_STATUS, 32'h98);
  endtask : t_idle
  task t_sleep;
    apb(1'b1, OFS_LINE, 32'h00);
    @(posedge i_clock);
    i_port9 <= 8'h01;
    pl(9, 10'h0, 8'h0);
    chk("sleep clocks", 32'({o_cpu_clk_en, o_lf_clk_en}), 32'h0);
    @(posedge i_clock);
    i_port9 <= 8'h00;
    see(32'h5);
    rd(OFS_STATUS, 32'h90);
  endtask : t_sleep
  task t_edge;
    apb(1'b1, OFS_MASK, 32'h02);
    apb(1'b1, OFS_CONTROL, 32'hc0);
    @(posedge i_clock);
    i_ext_pin <= 4'h0;
    @(posedge i_clock);
    #1;
    chk("pin0 fall irq", 32'({o_irq_req, o_wake}), 32'h2);
    apb(1'b1, OFS_MASK, 32'h04);
    apb(1'b1, OFS_CONTROL, 32'hc0);
    @(posedge i_clock);
    i_ext_pin[1] <= 1'b1;
    @(posedge i_clock);
    i_ext_pin[1] <= 1'b0;
    @(posedge i_clock);
    #1;
    chk("pin1 fall irq", 32'({o_irq_req, o_wake}), 32'h2);
  endtask : t_edge

  initial begin
    i_reset = 1'b1;
    bus = '0;
    op = '0;
    {i_target, i_acc, i_port9, i_ext_pin} = '0;
    {i_ring_detect_n, i_carrier_detect_n, i_fsk_data, i_battery_low_n} = 4'b1010;
    {i_cw_none, i_ring_time_n} = 2'b11;
    repeat (6) @(posedge i_clock);
    i_reset <= 1'b0;
    t_line();
    t_ram();
    t_pc();
    t_idle();
    t_sleep();
    t_edge();
    complete_run();
  end
endmodule : cid_mcu_operational_registers_tb_top
